// *** lagd_alarm_core.sv ***
`timescale 1ns/1ns
// Function
// RULE_01 - transmit remote alarm while its enable bit is set
// RULE_02 - format bit picks T1 or J1 transmitted remote alarm
// RULE_03 - in T1 ESF a type bit picks normal or CI remote alarm
// RULE_04 - receive format bit picks T1 or J1 remote alarm criteria
// RULE_05 - E1 auto blue alarm on loss of frame, received AIS or LOS
// RULE_06 - E1 auto remote alarm on same causes or CRC-4 sync timeout
// RULE_07 - host never enables both automatic alarms together
// RULE_08 - blue CI pattern repeats every 1.26 s: ones then signature
// RULE_09 - signature block 6176 bits, zeros at 3088, 3474 and 5790
// RULE_10 - blue CI detection ignores the configured framing format
// RULE_11 - blue CI flag sets only while realtime AIS is asserted
// RULE_12 - blue CI flag re-sets about every 1.2 s while present
// RULE_13 - host clears CI flags after reading and polls alarms too
// RULE_14 - yellow CI: yellow code interleaved with the CI code
// RULE_15 - yellow CI flag sets on CI code while realtime RAI is set
// RULE_16 - yellow CI integration comes from the two BOC filter bits
// RULE_17 - yellow CI flag re-sets about every 1.1 s while present
// RULE_18 - integration bit gives 200 ms ESF remote alarm integration
// RULE_19 - framer n registers sit at framer-1 offset plus (n-1)*200h
// RULE_20 - writing one clears a latched flag until it sets again
// RULE_21 - automatic alarms stop once no cause remains
// RULE_22 - automatic blue alarm replaces transmit data with all ones
module lagd_alarm_core #(
  parameter int FRAMER_INDEX = 1,
  parameter int unsigned CRC4_WAIT = lagd_pkg::CRC4_WAIT_CYCLES,
  parameter int unsigned RAI_INTEGRATE = lagd_pkg::RAI_INTEGRATE_CYCLES,
  parameter int unsigned BLUE_CI_REPEAT = lagd_pkg::BLUE_CI_REPEAT_CYCLES,
  parameter int unsigned YELLOW_CI_REPEAT =
    lagd_pkg::YELLOW_CI_REPEAT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [12:0] hostAddr,
  input wire logic hostWrEn,
  input wire logic hostRdEn,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  input wire logic e1Mode,
  input wire logic esfMode,
  input wire logic crc4Enable,
  input wire logic rxFasSync,
  input wire logic rxCrc4MfSync,
  input wire logic rxLossOfFrame,
  input wire logic rxLossOfSignal,
  input wire logic rxBlueAlarmRealtime,
  input wire logic rxYellowRawT1,
  input wire logic rxYellowRawJ1,
  input wire logic rxBit,
  input wire logic rxBitValid,
  input wire logic fdlBit,
  input wire logic fdlBitValid,
  input wire logic txDataIn,
  output logic txData,
  output logic txBlueAlarm,
  output logic txRemoteAlarm,
  output logic txRemoteAlarmJ1,
  output logic txRemoteAlarmCi,
  output logic rxYellowAlarmRealtime,
  output logic rxBlueCiLatched,
  output logic rxYellowCiLatched
);

  localparam logic [12:0] FRAMER_BASE =
    13'((FRAMER_INDEX - 1) * lagd_pkg::FRAMER_STRIDE);
  localparam logic [lagd_pkg::TIMER_W-1:0] CRC4_LAST =
    lagd_pkg::TIMER_W'(CRC4_WAIT - 1);
  localparam logic [lagd_pkg::TIMER_W-1:0] RAI_LAST =
    lagd_pkg::TIMER_W'(RAI_INTEGRATE - 1);

  // ---- host registers ----
  logic [7:0] rxT1Ctrl2_q, rxT1Ctrl2_d;
  logic [7:0] txCtrl1_q, txCtrl1_d;
  logic [7:0] txCtrl2_q, txCtrl2_d;
  logic [7:0] txCtrl4_q, txCtrl4_d;
  logic [1:0] bocCtrl_q, bocCtrl_d;
  logic [7:0] rdData_q, rdData_d;
  logic hitRxT1Ctrl2, hitTxCtrl1, hitTxCtrl2, hitTxCtrl4, hitCi, hitBoc;
  logic clearBlueCi, clearYellowCi;
  logic blueCi_q, blueCi_d, yellowCi_q, yellowCi_d;

  // address decode relative to this framer's window
  always_comb begin
    hitRxT1Ctrl2 = hostAddr ==
      FRAMER_BASE + lagd_pkg::RX_T1_CONTROL_SECOND_OFS; // RULE_19
    hitTxCtrl1 = hostAddr ==
      FRAMER_BASE + lagd_pkg::TX_CONTROL_FIRST_OFS; // RULE_19
    hitTxCtrl2 = hostAddr == FRAMER_BASE + lagd_pkg::TX_CONTROL_SECOND_OFS;
    hitTxCtrl4 = hostAddr == FRAMER_BASE + lagd_pkg::TX_CONTROL_FOURTH_OFS;
    hitCi = hostAddr == FRAMER_BASE + lagd_pkg::CI_LATCHED_STATUS_OFS;
    hitBoc = hostAddr == FRAMER_BASE + lagd_pkg::RX_BOC_CONTROL_OFS;
  end

  // write-one-to-clear strobes for the latched flags
  assign clearBlueCi = hostWrEn && hitCi &&
    hostWrData[lagd_pkg::RX_BLUE_CI_LATCHED_BIT]; // RULE_20
  assign clearYellowCi = hostWrEn && hitCi &&
    hostWrData[lagd_pkg::RX_YELLOW_CI_LATCHED_BIT]; // RULE_20

  // register writes and registered read-back; unmapped reads give zero
  always_comb begin
    rxT1Ctrl2_d = rxT1Ctrl2_q;
    txCtrl1_d = txCtrl1_q;
    txCtrl2_d = txCtrl2_q;
    txCtrl4_d = txCtrl4_q;
    bocCtrl_d = bocCtrl_q;
    rdData_d = rdData_q;
    if (hostWrEn && hitRxT1Ctrl2) begin
      rxT1Ctrl2_d = hostWrData;
    end
    if (hostWrEn && hitTxCtrl1) begin
      txCtrl1_d = hostWrData;
    end
    if (hostWrEn && hitTxCtrl2) begin
      txCtrl2_d = hostWrData;
    end
    if (hostWrEn && hitTxCtrl4) begin
      txCtrl4_d = hostWrData;
    end
    if (hostWrEn && hitBoc) begin
      bocCtrl_d = hostWrData[1:0];
    end
    if (hostRdEn) begin
      rdData_d = 8'h00;
      if (hitRxT1Ctrl2) rdData_d = rxT1Ctrl2_q;
      if (hitTxCtrl1) rdData_d = txCtrl1_q;
      if (hitTxCtrl2) rdData_d = txCtrl2_q;
      if (hitTxCtrl4) rdData_d = txCtrl4_q;
      if (hitBoc) rdData_d = {6'h00, bocCtrl_q};
      if (hitCi) rdData_d = {6'h00, yellowCi_q, blueCi_q};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxT1Ctrl2_q <= lagd_pkg::CTRL_RESET;
      txCtrl1_q <= lagd_pkg::CTRL_RESET;
      txCtrl2_q <= lagd_pkg::CTRL_RESET;
      txCtrl4_q <= lagd_pkg::CTRL_RESET;
      bocCtrl_q <= 2'h0;
      rdData_q <= 8'h00;
    end else begin
      rxT1Ctrl2_q <= rxT1Ctrl2_d;
      txCtrl1_q <= txCtrl1_d;
      txCtrl2_q <= txCtrl2_d;
      txCtrl4_q <= txCtrl4_d;
      bocCtrl_q <= bocCtrl_d;
      rdData_q <= rdData_d;
    end
  end

  // ---- E1 CRC-4 multiframe search timer ----
  logic [lagd_pkg::TIMER_W-1:0] crcCnt_q, crcCnt_d;
  logic crcFail_q, crcFail_d;

  // counts from FAS sync; a failure stands until multiframe sync or FAS loss
  always_comb begin
    crcCnt_d = '0;
    crcFail_d = 1'b0;
    if (e1Mode && crc4Enable && rxFasSync && !rxCrc4MfSync) begin
      crcCnt_d = crcCnt_q;
      crcFail_d = crcFail_q;
      if (crcCnt_q == CRC4_LAST) begin
        crcFail_d = 1'b1; // RULE_06
      end else begin
        crcCnt_d = crcCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      crcCnt_q <= '0;
      crcFail_q <= 1'b0;
    end else begin
      crcCnt_q <= crcCnt_d;
      crcFail_q <= crcFail_d;
    end
  end

  // ---- transmit alarm selection ----
  logic rxCause, autoBlue, autoRemote;
  logic txData_d, txBlue_d, txRemote_d, txJ1_d, txCi_d;
  logic txData_q, txBlue_q, txRemote_q, txJ1_q, txCi_q;

  // automatic alarms follow their causes level by level, so they drop the
  // cycle after the last cause goes; blue wins if both are misconfigured
  always_comb begin
    rxCause = rxLossOfFrame || rxBlueAlarmRealtime || rxLossOfSignal;
    autoBlue = e1Mode && rxCause &&
      txCtrl2_q[lagd_pkg::AUTO_BLUE_ALARM_ENABLE_BIT]; // RULE_05 RULE_21
    autoRemote = e1Mode && !autoBlue && // RULE_07
      txCtrl2_q[lagd_pkg::AUTO_REMOTE_ALARM_ENABLE_BIT] &&
      (rxCause || crcFail_q); // RULE_06 RULE_21
    txBlue_d = autoBlue;
    txData_d = autoBlue ? 1'b1 : txDataIn; // RULE_22
    txRemote_d = txCtrl1_q[lagd_pkg::TX_REMOTE_ALARM_ENABLE_BIT] ||
      autoRemote; // RULE_01
    txJ1_d = !e1Mode &&
      txCtrl2_q[lagd_pkg::TX_REMOTE_ALARM_FORMAT_SEL_BIT]; // RULE_02
    txCi_d = !e1Mode && esfMode &&
      txCtrl4_q[lagd_pkg::TX_REMOTE_ALARM_TYPE_SEL_BIT]; // RULE_03
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txData_q <= 1'b1;
      txBlue_q <= 1'b0;
      txRemote_q <= 1'b0;
      txJ1_q <= 1'b0;
      txCi_q <= 1'b0;
    end else begin
      txData_q <= txData_d;
      txBlue_q <= txBlue_d;
      txRemote_q <= txRemote_d;
      txJ1_q <= txJ1_d;
      txCi_q <= txCi_d;
    end
  end

  // ---- receive remote alarm criteria and integration ----
  logic yellowRaw;
  logic [lagd_pkg::TIMER_W-1:0] intCnt_q, intCnt_d;
  logic yellowRt_q, yellowRt_d;

  // the raw indication must stand unbroken for the whole integration span
  always_comb begin
    yellowRaw = rxT1Ctrl2_q[lagd_pkg::RX_REMOTE_ALARM_FORMAT_SEL_BIT] ?
      rxYellowRawJ1 : rxYellowRawT1; // RULE_04
    intCnt_d = '0;
    yellowRt_d = yellowRaw;
    if (esfMode &&
        rxT1Ctrl2_q[lagd_pkg::RX_REMOTE_ALARM_INTEGRATION_BIT]) begin
      yellowRt_d = 1'b0;
      if (yellowRaw) begin
        intCnt_d = intCnt_q;
        if (intCnt_q == RAI_LAST) begin
          yellowRt_d = 1'b1; // RULE_18
        end else begin
          intCnt_d = intCnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      intCnt_q <= '0;
      yellowRt_q <= 1'b0;
    end else begin
      intCnt_q <= intCnt_d;
      yellowRt_q <= yellowRt_d;
    end
  end

  // ---- blue CI signature tracker on the raw receive bits ----
  lagd_pkg::lagd_sig_state_t sig_q, sig_d;
  logic [12:0] gapCnt_q, gapCnt_d;
  logic [12:0] gapNow;
  logic sigFound_q, sigFound_d;

  // framing is never consulted, so any T1 format works; a zero at the
  // wrong spacing simply becomes the new first-zero candidate
  always_comb begin
    sig_d = sig_q;
    gapCnt_d = gapCnt_q;
    sigFound_d = 1'b0;
    gapNow = gapCnt_q + 13'h1;
    if (rxBitValid) begin // RULE_10
      if (rxBit) begin
        if (gapCnt_q == lagd_pkg::SIG_GAP_MAX) begin
          sig_d = lagd_pkg::SIG_HUNT;
        end else begin
          gapCnt_d = gapNow;
        end
      end else begin
        gapCnt_d = 13'h0;
        case (sig_q)
          lagd_pkg::SIG_HUNT: begin
            sig_d = lagd_pkg::SIG_GAP_ONE;
          end
          lagd_pkg::SIG_GAP_ONE: begin
            if (gapNow == lagd_pkg::SIG_GAP_AB) begin
              sig_d = lagd_pkg::SIG_GAP_TWO; // RULE_09
            end
          end
          lagd_pkg::SIG_GAP_TWO: begin
            sig_d = lagd_pkg::SIG_GAP_ONE;
            if (gapNow == lagd_pkg::SIG_GAP_BC) begin
              sigFound_d = 1'b1; // RULE_08 RULE_09
            end
          end
          default: begin
            sig_d = lagd_pkg::SIG_HUNT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sig_q <= lagd_pkg::SIG_HUNT;
      gapCnt_q <= 13'h0;
      sigFound_q <= 1'b0;
    end else begin
      sig_q <= sig_d;
      gapCnt_q <= gapCnt_d;
      sigFound_q <= sigFound_d;
    end
  end

  // ---- yellow CI code word detector on the data link ----
  logic [15:0] boc_q, boc_d;
  logic [15:0] bocNext;
  logic [3:0] bocBit_q, bocBit_d;
  logic bocAligned_q, bocAligned_d;
  logic [3:0] bocRun_q, bocRun_d;
  logic [3:0] bocNeed;
  logic yellowCiSeen;

  // a word-aligned run of CI code words is the integration; one bad word
  // drops alignment and restarts the run
  always_comb begin
    bocNext = {fdlBit, boc_q[15:1]};
    boc_d = boc_q;
    bocBit_d = bocBit_q;
    bocAligned_d = bocAligned_q;
    bocRun_d = bocRun_q;
    case (bocCtrl_q) // RULE_16
      2'h0: bocNeed = lagd_pkg::BOC_NEED_0;
      2'h1: bocNeed = lagd_pkg::BOC_NEED_1;
      2'h2: bocNeed = lagd_pkg::BOC_NEED_2;
      default: bocNeed = lagd_pkg::BOC_NEED_3;
    endcase
    if (fdlBitValid && esfMode && !e1Mode) begin
      boc_d = bocNext;
      bocBit_d = bocBit_q + 4'h1;
      if (!bocAligned_q) begin
        if (bocNext == lagd_pkg::YELLOW_CI_CODE) begin // RULE_14
          bocAligned_d = 1'b1;
          bocBit_d = 4'h0;
          bocRun_d = 4'h1;
        end
      end else if (bocBit_q == lagd_pkg::BOC_LAST_BIT) begin
        if (bocNext == lagd_pkg::YELLOW_CI_CODE) begin
          if (bocRun_q != 4'hf) bocRun_d = bocRun_q + 4'h1;
        end else begin
          bocAligned_d = 1'b0;
          bocRun_d = 4'h0;
        end
      end
    end
    yellowCiSeen = bocAligned_q && (bocRun_q >= bocNeed); // RULE_16
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boc_q <= 16'h0000;
      bocBit_q <= 4'h0;
      bocAligned_q <= 1'b0;
      bocRun_q <= 4'h0;
    end else begin
      boc_q <= boc_d;
      bocBit_q <= bocBit_d;
      bocAligned_q <= bocAligned_d;
      bocRun_q <= bocRun_d;
    end
  end

  // ---- latched CI flags with paced re-set ----
  logic blueFire, yellowFire;

  lagd_repeat_pacer #(
    .HOLD_CYCLES(BLUE_CI_REPEAT)
  ) u_blue_pacer (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(sigFound_q && rxBlueAlarmRealtime), // RULE_11
    .fire(blueFire)
  );

  lagd_repeat_pacer #(
    .HOLD_CYCLES(YELLOW_CI_REPEAT)
  ) u_yellow_pacer (
    .clock(clock),
    .rst_n(rst_n),
    .trigger(yellowCiSeen && yellowRt_q), // RULE_15
    .fire(yellowFire)
  );

  // a set in the same cycle as a host clear wins, so no event is lost
  always_comb begin
    blueCi_d = blueFire || (blueCi_q && !clearBlueCi); // RULE_12 RULE_20
    yellowCi_d = yellowFire ||
      (yellowCi_q && !clearYellowCi); // RULE_17 RULE_20
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blueCi_q <= 1'b0;
      yellowCi_q <= 1'b0;
    end else begin
      blueCi_q <= blueCi_d;
      yellowCi_q <= yellowCi_d;
    end
  end

  assign hostRdData = rdData_q;
  assign txData = txData_q;
  assign txBlueAlarm = txBlue_q;
  assign txRemoteAlarm = txRemote_q;
  assign txRemoteAlarmJ1 = txJ1_q;
  assign txRemoteAlarmCi = txCi_q;
  assign rxYellowAlarmRealtime = yellowRt_q;
  assign rxBlueCiLatched = blueCi_q;
  assign rxYellowCiLatched = yellowCi_q;

endmodule : lagd_alarm_core

// *** lagd_pkg.sv ***
package lagd_pkg;

  // clock and host port geometry
  localparam int CLOCK_HZ = 20_000_000;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] FRAMER_STRIDE = 13'h200;

  // framer-1 register offsets
  localparam logic [12:0] RX_T1_CONTROL_SECOND_OFS = 13'h014;
  localparam logic [12:0] TX_CONTROL_FIRST_OFS = 13'h181;
  localparam logic [12:0] TX_CONTROL_SECOND_OFS = 13'h182;
  localparam logic [12:0] TX_CONTROL_FOURTH_OFS = 13'h186;
  localparam logic [12:0] CI_LATCHED_STATUS_OFS = 13'h1f0;
  localparam logic [12:0] RX_BOC_CONTROL_OFS = 13'h1f1;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // field positions
  localparam int TX_REMOTE_ALARM_ENABLE_BIT = 0;
  localparam int TX_REMOTE_ALARM_FORMAT_SEL_BIT = 0;
  localparam int AUTO_REMOTE_ALARM_ENABLE_BIT = 1;
  localparam int AUTO_BLUE_ALARM_ENABLE_BIT = 2;
  localparam int TX_REMOTE_ALARM_TYPE_SEL_BIT = 0;
  localparam int RX_REMOTE_ALARM_FORMAT_SEL_BIT = 0;
  localparam int RX_REMOTE_ALARM_INTEGRATION_BIT = 1;
  localparam int RX_BLUE_CI_LATCHED_BIT = 0;
  localparam int RX_YELLOW_CI_LATCHED_BIT = 1;
  localparam int BOC_FILTER_SEL_LO_BIT = 0;
  localparam int BOC_FILTER_SEL_HI_BIT = 1;

  // times as printed, and their cycle counts
  localparam int CRC4_WAIT_MS = 128;
  localparam int RAI_INTEGRATE_MS = 200;
  localparam int BLUE_CI_REPEAT_MS = 1200;
  localparam int YELLOW_CI_REPEAT_MS = 1100;
  localparam int CRC4_WAIT_CYCLES = CLOCK_HZ / 1000 * CRC4_WAIT_MS;
  localparam int RAI_INTEGRATE_CYCLES = CLOCK_HZ / 1000 * RAI_INTEGRATE_MS;
  localparam int BLUE_CI_REPEAT_CYCLES = CLOCK_HZ / 1000 * BLUE_CI_REPEAT_MS;
  localparam int YELLOW_CI_REPEAT_CYCLES =
    CLOCK_HZ / 1000 * YELLOW_CI_REPEAT_MS;
  localparam int TIMER_W = 25;

  // blue-alarm customer-installation signature, bit numbers in a block
  localparam logic [12:0] SIG_BLOCK_BITS = 13'd6176;
  localparam logic [12:0] SIG_ZERO_A = 13'd3088;
  localparam logic [12:0] SIG_ZERO_B = 13'd3474;
  localparam logic [12:0] SIG_ZERO_C = 13'd5790;
  localparam logic [12:0] SIG_GAP_AB = SIG_ZERO_B - SIG_ZERO_A;
  localparam logic [12:0] SIG_GAP_BC = SIG_ZERO_C - SIG_ZERO_B;
  localparam logic [12:0] SIG_GAP_MAX = 13'h1fff;

  // yellow-alarm customer-installation code word, first bit in bit 0
  localparam logic [15:0] YELLOW_CI_CODE = 16'h3eff;
  localparam logic [3:0] BOC_LAST_BIT = 4'hf;

  // consecutive code words needed per filter setting
  localparam logic [3:0] BOC_NEED_0 = 4'h1;
  localparam logic [3:0] BOC_NEED_1 = 4'h3;
  localparam logic [3:0] BOC_NEED_2 = 4'h5;
  localparam logic [3:0] BOC_NEED_3 = 4'h7;

  typedef enum logic [2:0] {
    SIG_HUNT = 3'b001,
    SIG_GAP_ONE = 3'b010,
    SIG_GAP_TWO = 3'b100
  } lagd_sig_state_t;

endpackage : lagd_pkg

// *** lagd_repeat_pacer.sv ***
`timescale 1ns/1ns
module lagd_repeat_pacer #(
  parameter int unsigned HOLD_CYCLES = 1000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trigger,
  output logic fire
);

  localparam logic [lagd_pkg::TIMER_W-1:0] HOLD_LOAD =
    lagd_pkg::TIMER_W'(HOLD_CYCLES - 1);

  logic [lagd_pkg::TIMER_W-1:0] hold_q;
  logic [lagd_pkg::TIMER_W-1:0] hold_d;
  logic fire_q;
  logic fire_d;

  // one fire per holdoff window, so a standing condition re-sets the flag
  // at a steady rate instead of every detection
  always_comb begin
    hold_d = hold_q;
    fire_d = 1'b0;
    if (hold_q != '0) begin
      hold_d = hold_q - 1'b1;
    end else if (trigger) begin
      fire_d = 1'b1;
      hold_d = HOLD_LOAD;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_q <= '0;
      fire_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      fire_q <= fire_d;
    end
  end

  assign fire = fire_q;

endmodule : lagd_repeat_pacer

// *** lagd_alarm_core_asserts.sv ***
`timescale 1ns/1ns
// port-level watcher for one framer's alarm core
module lagd_alarm_core_asserts #(
  parameter int FRAMER_INDEX = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [12:0] hostAddr,
  input wire logic hostWrEn,
  input wire logic [7:0] hostWrData,
  input wire logic e1Mode,
  input wire logic esfMode,
  input wire logic rxLossOfFrame,
  input wire logic rxLossOfSignal,
  input wire logic rxBlueAlarmRealtime,
  input wire logic txDataIn,
  input wire logic txData,
  input wire logic txBlueAlarm,
  input wire logic txRemoteAlarm,
  input wire logic txRemoteAlarmJ1,
  input wire logic txRemoteAlarmCi,
  input wire logic rxYellowAlarmRealtime,
  input wire logic rxBlueCiLatched,
  input wire logic rxYellowCiLatched
);
  localparam logic [12:0] BASE = 13'((FRAMER_INDEX - 1) * 512);
  localparam logic [12:0] OFS [3] = '{13'h181, 13'h182, 13'h186};
  logic [7:0] ctl_q [3];
  logic [7:0] ctl_d [3];
  logic cause;
  logic clrBlue;
  // shadow of the control bytes, as the checker cannot see inside
  always_comb begin
    ctl_d = ctl_q;
    for (int i = 0; i < 3; i++) begin
      if (hostWrEn && hostAddr == BASE + OFS[i]) begin
        ctl_d[i] = hostWrData;
      end
    end
  end
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      ctl_q[i] <= rst_n ? ctl_d[i] : 8'h00;
    end
  end
  // receive causes and the host clear of the blue flag
  assign cause = rxLossOfFrame | rxBlueAlarmRealtime | rxLossOfSignal;
  assign clrBlue = hostWrEn && hostAddr == BASE + 13'h1f0 && hostWrData[0];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // past reset guards keep pre-reset samples out of the equalities
  a_auto_blue: assert property ($past(rst_n) |->
    txBlueAlarm == $past(e1Mode && ctl_q[1][2] && cause))
    else $error("auto blue alarm does not follow its causes");
  a_remote_t1: assert property ($past(rst_n) && !$past(e1Mode) |->
    txRemoteAlarm == $past(ctl_q[0][0]))
    else $error("remote alarm does not follow its enable");
  a_auto_remote: assert property (e1Mode && ctl_q[1][1] &&
    !ctl_q[1][2] && cause |=> txRemoteAlarm)
    else $error("auto remote alarm missing");
  a_j1_select: assert property ($past(rst_n) |->
    txRemoteAlarmJ1 == $past(!e1Mode && ctl_q[1][0]))
    else $error("remote alarm format wrong");
  a_ci_select: assert property ($past(rst_n) |->
    txRemoteAlarmCi == $past(!e1Mode && esfMode && ctl_q[2][0]))
    else $error("remote alarm type wrong");
  a_blue_data: assert property ($past(rst_n) |->
    txData == ($past(txDataIn) || txBlueAlarm))
    else $error("transmit data not ones during blue alarm");
  a_blue_gate: assert property ($rose(rxBlueCiLatched) |->
    $past(rxBlueAlarmRealtime, 2))
    else $error("blue ci flag set without realtime ais");
  a_yellow_gate: assert property ($rose(rxYellowCiLatched) |->
    $past(rxYellowAlarmRealtime && esfMode && !e1Mode, 2))
    else $error("yellow ci flag set without realtime rai");
  a_blue_holds: assert property (rxBlueCiLatched && !clrBlue |=>
    rxBlueCiLatched)
    else $error("blue ci flag dropped without a clear");
  c_blue_ci: cover property ($rose(rxBlueCiLatched));
  c_yellow_ci: cover property ($rose(rxYellowCiLatched));
  c_auto_blue: cover property ($rose(txBlueAlarm));
endmodule : lagd_alarm_core_asserts

// *** lagd_line_model.sv ***
`timescale 1ns/1ns
// far-end terminal: raw line bits and esf data link bits
module lagd_line_model (
  input wire logic clock,
  output logic rxBit,
  output logic rxBitValid,
  output logic fdlBit,
  output logic fdlBitValid
);
  // idle line carries unframed ones, no strobes
  initial begin
    rxBit = 1'b1;
    rxBitValid = 1'b0;
    fdlBit = 1'b0;
    fdlBitValid = 1'b0;
  end
  // one signature block, one bit a clock, zeros at the three marks
  task automatic send_sig;
    for (int i = 0; i < 6176; i++) begin
      rxBit = !(i == 3088 || i == 3474 || i == 5790);
      rxBitValid = 1'b1;
      @(negedge clock);
    end
    rxBit = 1'b1;
    rxBitValid = 1'b0;
    @(negedge clock);
  endtask : send_sig
  // link words, first bit in bit 0; stale bit inverted so it never helps
  task automatic send_words(input logic [15:0] w, input int n);
    for (int j = 0; j < n * 16; j++) begin
      fdlBit = w[j % 16];
      fdlBitValid = 1'b1;
      @(negedge clock);
    end
    fdlBit = !fdlBit;
    fdlBitValid = 1'b0;
    @(negedge clock);
  endtask : send_words
endmodule : lagd_line_model

// *** testbench.sv ***
`timescale 1ns/1ns
// framer two instance, short timers so the run stays brief
module testbench;
  localparam logic [12:0] B = 13'h200;
  logic clock = 1'b0, rst_n = 1'b0, hostWrEn = 1'b0, hostRdEn = 1'b0;
  logic [12:0] hostAddr = 13'h0000;
  logic [7:0] hostWrData = 8'h00;
  logic [7:0] hostRdData;
  logic e1Mode = 1'b0, esfMode = 1'b0, crc4Enable = 1'b0, rxFasSync = 1'b0;
  logic rxCrc4MfSync = 1'b0, rxLossOfFrame = 1'b0, rxLossOfSignal = 1'b0;
  logic rxBlueAlarmRealtime = 1'b0, rxYellowRawT1 = 1'b0;
  logic rxYellowRawJ1 = 1'b0, txDataIn = 1'b0;
  logic rxBit, rxBitValid, fdlBit, fdlBitValid, txData, txBlueAlarm;
  logic txRemoteAlarm, txRemoteAlarmJ1, txRemoteAlarmCi;
  logic rxYellowAlarmRealtime, rxBlueCiLatched, rxYellowCiLatched;
  int fails = 0;
  int n_tests = 0;
  lagd_alarm_core #(.FRAMER_INDEX(2), .CRC4_WAIT(50), .RAI_INTEGRATE(40),
    .BLUE_CI_REPEAT(200), .YELLOW_CI_REPEAT(200)) lagd_alarm_core_i (
    .clock, .rst_n, .hostAddr, .hostWrEn, .hostRdEn, .hostWrData, .hostRdData,
    .e1Mode, .esfMode, .crc4Enable, .rxFasSync, .rxCrc4MfSync, .rxLossOfFrame,
    .rxLossOfSignal, .rxBlueAlarmRealtime, .rxYellowRawT1, .rxYellowRawJ1,
    .rxBit, .rxBitValid, .fdlBit, .fdlBitValid, .txDataIn, .txData,
    .txBlueAlarm, .txRemoteAlarm, .txRemoteAlarmJ1, .txRemoteAlarmCi,
    .rxYellowAlarmRealtime, .rxBlueCiLatched, .rxYellowCiLatched);
  lagd_line_model lagd_line_model_i (.clock, .rxBit, .rxBitValid, .fdlBit,
    .fdlBitValid);
  always #25 clock = ~clock;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chb
  // strobe one cycle, then one idle cycle so strobes never merge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    hostAddr = B + a;
    hostWrData = d;
    hostWrEn = 1'b1;
    @(negedge clock);
    hostWrEn = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    hostAddr = B + a;
    hostRdEn = 1'b1;
    @(negedge clock);
    hostRdEn = 1'b0;
    @(negedge clock);
    chk(hostRdData, exp);
  endtask : rd
  task automatic t_regs;
    logic [12:0] ofs [4] = '{13'h014, 13'h181, 13'h182, 13'h186};
    foreach (ofs[i]) begin
      rd(ofs[i], 8'h00);
      wr(ofs[i], 8'h08);
      rd(ofs[i], 8'h08);
      wr(ofs[i], 8'h00);
    end
    wr(13'h181, 8'h08);
    rd(13'h1f81, 8'h00);
    rd(13'h1f2, 8'h00);
    wr(13'h181, 8'h00);
  endtask : t_regs
  task automatic t_tx;
    esfMode = 1'b1;
    wr(13'h181, 8'h01);
    chb(txRemoteAlarm, 1'b1);
    wr(13'h182, 8'h01);
    chb(txRemoteAlarmJ1, 1'b1);
    wr(13'h186, 8'h01);
    chb(txRemoteAlarmCi, 1'b1);
    esfMode = 1'b0;
    cyc(2);
    chb(txRemoteAlarmCi, 1'b0);
    wr(13'h181, 8'h00);
    chb(txRemoteAlarm, 1'b0);
    wr(13'h182, 8'h00);
    chb(txRemoteAlarmJ1, 1'b0);
    wr(13'h186, 8'h00);
  endtask : t_tx
  // each cause alone, first under auto blue, then under auto remote
  task automatic t_auto;
    e1Mode = 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr(13'h182, e ? 8'h02 : 8'h04);
      for (int k = 0; k < 3; k++) begin
        {rxLossOfFrame, rxBlueAlarmRealtime, rxLossOfSignal} = 3'b100 >> k;
        cyc(2);
        chb(e ? txRemoteAlarm : txBlueAlarm, 1'b1);
        chb(txData, e == 0);
        {rxLossOfFrame, rxBlueAlarmRealtime, rxLossOfSignal} = 3'b000;
        cyc(2);
        chb(e ? txRemoteAlarm : txBlueAlarm, 1'b0);
        chb(txData, 1'b0);
      end
    end
    crc4Enable = 1'b1;
    rxFasSync = 1'b1;
    cyc(42);
    chb(txRemoteAlarm, 1'b0);
    cyc(14);
    chb(txRemoteAlarm, 1'b1);
    rxCrc4MfSync = 1'b1;
    cyc(2);
    chb(txRemoteAlarm, 1'b0);
    wr(13'h182, 8'h00);
    {e1Mode, crc4Enable, rxFasSync, rxCrc4MfSync} = 4'h0;
  endtask : t_auto
  task automatic t_integ;
    esfMode = 1'b1;
    rxYellowRawJ1 = 1'b1;
    cyc(2);
    chb(rxYellowAlarmRealtime, 1'b0);
    wr(13'h014, 8'h01);
    chb(rxYellowAlarmRealtime, 1'b1);
    rxYellowRawJ1 = 1'b0;
    wr(13'h014, 8'h02);
    rxYellowRawT1 = 1'b1;
    cyc(35);
    chb(rxYellowAlarmRealtime, 1'b0);
    cyc(10);
    chb(rxYellowAlarmRealtime, 1'b1);
    rxYellowRawT1 = 1'b0;
    wr(13'h014, 8'h00);
  endtask : t_integ
  task automatic t_blue;
    esfMode = 1'b0;
    lagd_line_model_i.send_sig();
    chb(rxBlueCiLatched, 1'b0);
    rxBlueAlarmRealtime = 1'b1;
    lagd_line_model_i.send_sig();
    chb(rxBlueCiLatched, 1'b1);
    rd(13'h1f0, 8'h01);
    wr(13'h1f0, 8'h02);
    chb(rxBlueCiLatched, 1'b1);
    wr(13'h1f0, 8'h01);
    cyc(300);
    chb(rxBlueCiLatched, 1'b0);
    esfMode = 1'b1;
    lagd_line_model_i.send_sig();
    chb(rxBlueCiLatched, 1'b1);
    wr(13'h1f0, 8'h01);
    rxBlueAlarmRealtime = 1'b0;
  endtask : t_blue
  // filter setting 3 asks for a run of seven code words
  task automatic t_yellow;
    wr(13'h1f1, 8'h03);
    lagd_line_model_i.send_words(16'h3eff, 7);
    chb(rxYellowCiLatched, 1'b0);
    lagd_line_model_i.send_words(16'h00ff, 2);
    rxYellowRawT1 = 1'b1;
    lagd_line_model_i.send_words(16'h3eff, 6);
    lagd_line_model_i.send_words(16'h00ff, 2);
    chb(rxYellowCiLatched, 1'b0);
    lagd_line_model_i.send_words(16'h3eff, 7);
    cyc(3);
    chb(rxYellowCiLatched, 1'b1);
    wr(13'h1f0, 8'h02);
    chb(rxYellowCiLatched, 1'b0);
    lagd_line_model_i.send_words(16'h3eff, 20);
    cyc(3);
    chb(rxYellowCiLatched, 1'b1);
  endtask : t_yellow
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    t_regs();
    t_tx();
    t_auto();
    t_integ();
    t_blue();
    t_yellow();
    complete_run();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    $display("BAD %0t run did not finish", $time);
    complete_run();
  end
endmodule : testbench
bind lagd_alarm_core lagd_alarm_core_asserts #(.FRAMER_INDEX(FRAMER_INDEX))
  lagd_alarm_core_asserts_i (.clock, .rst_n, .hostAddr, .hostWrEn,
  .hostWrData, .e1Mode, .esfMode, .rxLossOfFrame, .rxLossOfSignal,
  .rxBlueAlarmRealtime, .txDataIn, .txData, .txBlueAlarm, .txRemoteAlarm,
  .txRemoteAlarmJ1, .txRemoteAlarmCi, .rxYellowAlarmRealtime,
  .rxBlueCiLatched, .rxYellowCiLatched);
